/* shared/dmc_pkg.sv */
`default_nettype none
// ****************************************************************
// mode control constants
// ****************************************************************
package dmc_pkg;
    // command word layout
    localparam int CMD_W = 16;
    localparam int DATA_W = 8;
    localparam int IDX_W = 7;
    localparam int RW_BIT = 15;
    localparam int IDX_HI = 14;
    localparam int IDX_LO = 8;
    localparam logic CMD_WRITE = 1'b0;
    localparam logic CMD_READ = 1'b1;
    // register indexes
    localparam logic [6:0] IDX_MODE = 7'h14;
    localparam logic [6:0] IDX_ZCTL = 7'h15;
    localparam logic [6:0] IDX_FLAG = 7'h16;
    localparam logic [6:0] IDX_TAG = 7'h17;
    // mode_select_control fields
    localparam int MODE_SRST = 6;
    localparam int MODE_STREAM = 5;
    localparam int MODE_BYPASS = 4;
    localparam int MODE_MONO = 3;
    localparam int MODE_PICK = 2;
    localparam int MODE_RATE_HI = 1;
    localparam int MODE_RATE_LO = 0;
    // zero_output_control fields
    localparam int ZCTL_DZ_HI = 2;
    localparam int ZCTL_DZ_LO = 1;
    localparam int ZCTL_PCM_ZERO_FLAG_EN = 0;
    // zero_flag_status fields
    localparam int FLAG_RIGHT = 1;
    localparam int FLAG_LEFT = 0;
    // tag field width
    localparam int TAG_W = 5;
    // reset values
    localparam logic RST_STREAM = 1'b0;
    localparam logic RST_BYPASS = 1'b0;
    localparam logic RST_MONO = 1'b0;
    localparam logic RST_PICK = 1'b0;
    localparam logic [1:0] RST_DZ = 2'h0;
    localparam logic RST_PCM_ZERO_FLAG_EN = 1'b1;
    // modulator rate codes
    typedef enum logic [1:0] {
        OS_X64 = 2'b00,
        OS_X32 = 2'b01,
        OS_X128 = 2'b10,
        OS_RSV = 2'b11
    } dmc_os_type;
    // stream zero pattern codes, 1x selects the 96 hex pattern
    localparam logic [1:0] DZ_OFF = 2'b00;
    localparam logic [1:0] DZ_EVEN = 2'b01;
endpackage
`default_nettype wire

/* verilog/dmc_zero_flag.sv */
`default_nettype none
// ****************************************************************
// one channel zero flag qualifier
// ****************************************************************
module dmc_zero_flag (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic stream_mode,
    input wire logic pcm_zero_en,
    input wire logic [1:0] dz_sel,
    input wire logic pcm_zero_raw,
    input wire logic even_pat_raw,
    input wire logic hex96_pat_raw,
    output logic flag_r
);
    logic flag_nxt;

    // pick the detector that the current mode qualifies
    always_comb begin
        if (stream_mode) begin
            if (dz_sel == dmc_pkg::DZ_OFF) begin
                flag_nxt = 1'b0;
            end else if (dz_sel == dmc_pkg::DZ_EVEN) begin
                flag_nxt = even_pat_raw;
            end else begin
                flag_nxt = hex96_pat_raw;
            end
        end else begin
            flag_nxt = pcm_zero_en & pcm_zero_raw;
        end
    end

    // flag register drives pin and status alike
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule
`default_nettype wire

/* verilog/dmc_mode_regs.sv */
`default_nettype none
// Functional notes
// [R1] bypass bit selects external filter, reset 0
// [R2] single-channel bit gives balanced mono, reset 0
// [R3] channel pick acts only in mono
// [R4] stream mono takes primary data pin
// [R5] rate field 64x, 32x, 128x, 11 reserved
// [R6] host avoids 128x above 100 kHz
// [R7] host supplies clock above 256 fs
// [R8] stream mode reuses rate as bit-clock speed
// [R9] stream zero field: off, even, 96 hex
// [R10] pcm zero enable gates flags, reset 1
// [R11] flag bits mirror zero pins, reset 0
// [R12] flag and tag registers read only
// [R13] five-bit device tag readable
// [R14] command bit 15 selects write or read
// [R15] stream enable switches pcm and stream
// [R16] reserved bits ignore writes, read zero
module dmc_mode_regs #(
    // arbitrary neutral value
    parameter logic [4:0] DEV_TAG = 5'h01
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic pcm_zero_left_raw,
    input wire logic pcm_zero_right_raw,
    input wire logic even_pat_left_raw,
    input wire logic even_pat_right_raw,
    input wire logic hex96_pat_left_raw,
    input wire logic hex96_pat_right_raw,
    output logic rd_valid_r,
    output logic [7:0] rd_data_r,
    output logic filter_bypass_sel,
    output logic single_channel_sel,
    output logic channel_pick,
    output logic mono_right_sel_r,
    output logic stream_mono_primary_r,
    output logic one_bit_stream_mode,
    output logic [1:0] modulator_rate_sel,
    output logic [1:0] pcm_os_rate_r,
    output logic [1:0] stream_bitclk_rate_r,
    output logic [1:0] stream_zero_pattern_sel,
    output logic pcm_zero_flag_en,
    output logic sys_reset_pulse_r,
    output logic zero_pin_left,
    output logic zero_pin_right
);
    // ****************************************************************
    // command decode
    // ****************************************************************
    logic [6:0] cmd_idx;
    logic [7:0] cmd_data;
    logic cmd_rd;
    logic cmd_wr;
    logic [7:0] rd_mux;
    logic [1:0] flags;

    // registers that only ever answer reads
    function automatic logic is_ro_idx(input logic [6:0] idx);
        is_ro_idx = (idx == dmc_pkg::IDX_FLAG) || (idx == dmc_pkg::IDX_TAG);
    endfunction

    // registers that this block answers for
    function automatic logic is_own_idx(input logic [6:0] idx);
        is_own_idx = (idx == dmc_pkg::IDX_MODE) ||
            (idx == dmc_pkg::IDX_ZCTL) || is_ro_idx(idx);
    endfunction

    assign cmd_idx = cmd_word[dmc_pkg::IDX_HI:dmc_pkg::IDX_LO];
    assign cmd_data = cmd_word[dmc_pkg::DATA_W-1:0];
    // [R12] forced read mode
    assign cmd_rd = cmd_valid && is_own_idx(cmd_idx) &&
        (cmd_word[dmc_pkg::RW_BIT] == dmc_pkg::CMD_READ ||
        is_ro_idx(cmd_idx));
    // [R14] write select decode
    assign cmd_wr = cmd_valid && !is_ro_idx(cmd_idx) &&
        cmd_word[dmc_pkg::RW_BIT] == dmc_pkg::CMD_WRITE;

    // ****************************************************************
    // mode_select_control
    // ****************************************************************
    // [R1] bypass, [R2] mono, [R3] pick, [R15] stream bits
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            one_bit_stream_mode <= dmc_pkg::RST_STREAM;
            filter_bypass_sel <= dmc_pkg::RST_BYPASS;
            single_channel_sel <= dmc_pkg::RST_MONO;
            channel_pick <= dmc_pkg::RST_PICK;
        end else if (cmd_wr && cmd_idx == dmc_pkg::IDX_MODE) begin
            one_bit_stream_mode <= cmd_data[dmc_pkg::MODE_STREAM];
            filter_bypass_sel <= cmd_data[dmc_pkg::MODE_BYPASS];
            single_channel_sel <= cmd_data[dmc_pkg::MODE_MONO];
            channel_pick <= cmd_data[dmc_pkg::MODE_PICK];
        end
    end

    // [R5] rate field, reserved code leaves old value
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            modulator_rate_sel <= dmc_pkg::OS_X64;
        end else if (cmd_wr && cmd_idx == dmc_pkg::IDX_MODE &&
            cmd_data[1:0] != dmc_pkg::OS_RSV) begin
            modulator_rate_sel <=
                cmd_data[dmc_pkg::MODE_RATE_HI:dmc_pkg::MODE_RATE_LO];
        end
    end

    // write-only system reset strobe, one cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sys_reset_pulse_r <= 1'b0;
        end else begin
            sys_reset_pulse_r <= cmd_wr && cmd_idx == dmc_pkg::IDX_MODE &&
                cmd_data[dmc_pkg::MODE_SRST];
        end
    end

    // ****************************************************************
    // derived routing controls
    // ****************************************************************
    // [R3] pick gated by mono, [R4] stream mono uses primary pin
    // [R8] rate field steers pcm modulator or stream bit clock
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mono_right_sel_r <= 1'b0;
            stream_mono_primary_r <= 1'b0;
            pcm_os_rate_r <= dmc_pkg::OS_X64;
            stream_bitclk_rate_r <= dmc_pkg::OS_X64;
        end else begin
            mono_right_sel_r <= single_channel_sel && !one_bit_stream_mode
                && channel_pick;
            stream_mono_primary_r <= single_channel_sel &&
                one_bit_stream_mode;
            pcm_os_rate_r <= one_bit_stream_mode ? dmc_pkg::OS_X64 :
                modulator_rate_sel;
            stream_bitclk_rate_r <= one_bit_stream_mode ?
                modulator_rate_sel : dmc_pkg::OS_X64;
        end
    end

    // ****************************************************************
    // zero_output_control and zero flags
    // ****************************************************************
    // [R9] stream pattern, [R10] pcm enable
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stream_zero_pattern_sel <= dmc_pkg::RST_DZ;
            pcm_zero_flag_en <= dmc_pkg::RST_PCM_ZERO_FLAG_EN;
        end else if (cmd_wr && cmd_idx == dmc_pkg::IDX_ZCTL) begin
            stream_zero_pattern_sel <=
                cmd_data[dmc_pkg::ZCTL_DZ_HI:dmc_pkg::ZCTL_DZ_LO];
            pcm_zero_flag_en <= cmd_data[dmc_pkg::ZCTL_PCM_ZERO_FLAG_EN];
        end
    end

    // one qualifier per channel, left then right
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_zero
            dmc_zero_flag u_flag (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .stream_mode(one_bit_stream_mode),
                .pcm_zero_en(pcm_zero_flag_en),
                .dz_sel(stream_zero_pattern_sel),
                .pcm_zero_raw(ch == 0 ? pcm_zero_left_raw :
                    pcm_zero_right_raw),
                .even_pat_raw(ch == 0 ? even_pat_left_raw :
                    even_pat_right_raw),
                .hex96_pat_raw(ch == 0 ? hex96_pat_left_raw :
                    hex96_pat_right_raw),
                .flag_r(flags[ch])
            );
        end
    endgenerate

    // [R11] pins and status share one flop
    assign zero_pin_left = flags[dmc_pkg::FLAG_LEFT];
    assign zero_pin_right = flags[dmc_pkg::FLAG_RIGHT];

    // ****************************************************************
    // readback
    // ****************************************************************
    // [R16] reserved and write-only bits read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (cmd_idx)
            dmc_pkg::IDX_MODE: begin
                rd_mux[dmc_pkg::MODE_STREAM] = one_bit_stream_mode;
                rd_mux[dmc_pkg::MODE_BYPASS] = filter_bypass_sel;
                rd_mux[dmc_pkg::MODE_MONO] = single_channel_sel;
                rd_mux[dmc_pkg::MODE_PICK] = channel_pick;
                rd_mux[1:0] = modulator_rate_sel;
            end
            dmc_pkg::IDX_ZCTL: begin
                rd_mux[2:1] = stream_zero_pattern_sel;
                rd_mux[dmc_pkg::ZCTL_PCM_ZERO_FLAG_EN] = pcm_zero_flag_en;
            end
            dmc_pkg::IDX_FLAG: rd_mux[1:0] = flags;
            // [R13] tag readback
            dmc_pkg::IDX_TAG: rd_mux[dmc_pkg::TAG_W-1:0] = DEV_TAG;
            default: rd_mux = 8'h00;
        endcase
    end

    // [R14] read answer one cycle after the command
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
        end else begin
            rd_valid_r <= cmd_rd;
            rd_data_r <= cmd_rd ? rd_mux : 8'h00;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    bypass_write_a: assert property ( // R1
        cmd_wr && cmd_idx == dmc_pkg::IDX_MODE |=>
        filter_bypass_sel == $past(cmd_data[dmc_pkg::MODE_BYPASS]))
        else $error("bypass bit not stored");
    mono_write_a: assert property ( // R2
        cmd_wr && cmd_idx == dmc_pkg::IDX_MODE |=>
        single_channel_sel == $past(cmd_data[dmc_pkg::MODE_MONO]))
        else $error("mono bit not stored");
    pick_gated_a: assert property ( // R3
        mono_right_sel_r |-> $past(single_channel_sel && channel_pick &&
        !one_bit_stream_mode))
        else $error("pick acted outside pcm mono");
    stream_primary_a: assert property ( // R4
        ##1 stream_mono_primary_r ==
        $past(single_channel_sel && one_bit_stream_mode))
        else $error("stream mono source wrong");
    rate_legal_a: assert property ( // R5
        modulator_rate_sel != dmc_pkg::OS_RSV)
        else $error("reserved rate code held");
    stream_rate_a: assert property ( // R8
        one_bit_stream_mode && $stable(one_bit_stream_mode) |=>
        stream_bitclk_rate_r == $past(modulator_rate_sel))
        else $error("stream bit clock rate wrong");
    dz_off_a: assert property ( // R9
        one_bit_stream_mode && stream_zero_pattern_sel == dmc_pkg::DZ_OFF
        |=> !zero_pin_left && !zero_pin_right)
        else $error("stream flag not disabled");
    pcm_off_a: assert property ( // R10
        !one_bit_stream_mode && !pcm_zero_flag_en |=>
        !zero_pin_left && !zero_pin_right)
        else $error("pcm flag not disabled");
    flag_mirror_a: assert property ( // R11
        cmd_rd && cmd_idx == dmc_pkg::IDX_FLAG |=>
        rd_valid_r && rd_data_r[1:0] == $past({zero_pin_right,
        zero_pin_left}))
        else $error("flag readback differs from pins");
    ro_forced_a: assert property ( // R12
        cmd_valid && is_ro_idx(cmd_idx) |=> rd_valid_r)
        else $error("read-only register not read");
    tag_read_a: assert property ( // R13
        cmd_valid && cmd_idx == dmc_pkg::IDX_TAG |=>
        rd_data_r == {3'h0, DEV_TAG})
        else $error("tag readback wrong");
    mode_read_a: assert property ( // R14
        cmd_valid && cmd_idx == dmc_pkg::IDX_MODE &&
        cmd_word[dmc_pkg::RW_BIT] |=> rd_valid_r &&
        rd_data_r[dmc_pkg::MODE_STREAM] == $past(one_bit_stream_mode))
        else $error("mode read wrong");
    rsv_zero_a: assert property ( // R16
        rd_valid_r |-> !rd_data_r[7] && !rd_data_r[dmc_pkg::MODE_SRST])
        else $error("reserved bit read nonzero");
endmodule
`default_nettype wire

/* testbench/dmc_host_model.sv */
`default_nettype none
// ****************************************************************
// host controller driving the command port
// ****************************************************************
module dmc_host_model #(
    parameter int SAMPLE_KHZ = 48,
    parameter int CLK_RATIO = 512
) (
    input wire logic ref_clk,
    output logic cmd_valid,
    output logic [15:0] cmd_word
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam bit OK_128X = SAMPLE_KHZ <= 100 && CLK_RATIO > 256;

    // idle command port until the first command
    initial begin
        cmd_valid = 1'b0;
        cmd_word = 16'hFFFF;
    end

    // one command word: held over the taking edge, then released
    task automatic send(input logic rw, input logic [6:0] idx,
        input logic [7:0] data, input int gap);
        logic [7:0] w;
        w = data;
        if (!rw && idx == dmc_pkg::IDX_MODE && w[1:0] == 2'b10 && !OK_128X)
            w[1:0] = 2'b00;
        repeat (gap) @(negedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_word = {rw, idx, w};
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        cmd_word = ~cmd_word;  // a released word is driven inverted, not held
    endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`default_nettype none
// ****************************************************************
// mode control register bench
// ****************************************************************
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] TAG = 5'h0B;  // arbitrary tag value
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid;
    logic [15:0] cmd_word;
    logic [5:0] raw = 6'h00;  // hex r/l, even r/l, pcm r/l
    logic rd_valid_r, filter_bypass_sel, single_channel_sel, channel_pick;
    logic mono_right_sel_r, stream_mono_primary_r, one_bit_stream_mode;
    logic [7:0] rd_data_r;
    logic [1:0] modulator_rate_sel, pcm_os_rate_r, stream_bitclk_rate_r;
    logic [1:0] stream_zero_pattern_sel;
    logic pcm_zero_flag_en, sys_reset_pulse_r, zero_pin_left, zero_pin_right;
    int num_errors = 0;
    int n_checks = 0;
    logic [5:0] m_mode = 6'h00;  // stream, bypass, mono, pick, rate
    logic [2:0] m_zctl = 3'h1;  // pattern select, pcm enable

    // clock
    always #50 ref_clk = ~ref_clk;

    dmc_host_model i_dmc_host_model (
        .ref_clk(ref_clk),
        .cmd_valid(cmd_valid),
        .cmd_word(cmd_word)
    );

    dmc_mode_regs #(.DEV_TAG(TAG)) i_dmc_mode_regs (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .cmd_valid(cmd_valid),
        .cmd_word(cmd_word),
        .pcm_zero_left_raw(raw[0]),
        .pcm_zero_right_raw(raw[1]),
        .even_pat_left_raw(raw[2]),
        .even_pat_right_raw(raw[3]),
        .hex96_pat_left_raw(raw[4]),
        .hex96_pat_right_raw(raw[5]),
        .rd_valid_r(rd_valid_r),
        .rd_data_r(rd_data_r),
        .filter_bypass_sel(filter_bypass_sel),
        .single_channel_sel(single_channel_sel),
        .channel_pick(channel_pick),
        .mono_right_sel_r(mono_right_sel_r),
        .stream_mono_primary_r(stream_mono_primary_r),
        .one_bit_stream_mode(one_bit_stream_mode),
        .modulator_rate_sel(modulator_rate_sel),
        .pcm_os_rate_r(pcm_os_rate_r),
        .stream_bitclk_rate_r(stream_bitclk_rate_r),
        .stream_zero_pattern_sel(stream_zero_pattern_sel),
        .pcm_zero_flag_en(pcm_zero_flag_en),
        .sys_reset_pulse_r(sys_reset_pulse_r),
        .zero_pin_left(zero_pin_left),
        .zero_pin_right(zero_pin_right)
    );

    // ****************************************************************
    // reference model and compares
    // ****************************************************************
    // zero flag from the mode and pattern settings
    function automatic logic zexp(input logic pcm, input logic ev,
        input logic hex);
        if (!m_mode[5]) return m_zctl[0] & pcm;
        if (m_zctl[2]) return hex;
        return m_zctl[1] & ev;
    endfunction

    // readback byte of a register
    function automatic logic [7:0] model_rd(input logic [6:0] idx);
        case (idx)
            dmc_pkg::IDX_MODE: return {2'b00, m_mode};
            dmc_pkg::IDX_ZCTL: return {5'h00, m_zctl};
            dmc_pkg::IDX_FLAG: return {6'h00, zexp(raw[1], raw[3], raw[5]),
                zexp(raw[0], raw[2], raw[4])};
            default: return {3'h0, TAG};
        endcase
    endfunction

    task automatic chk_out(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask

    task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
        chk_out(got, exp);
    endtask

    // one command with its answer and model update
    task automatic cmd(input logic rw, input logic [6:0] idx,
        input logic [7:0] data);
        logic [8:0] exp;
        exp = 9'h000;
        if (idx inside {[7'h16:7'h17]} || (rw && idx inside {[7'h14:7'h15]}))
            exp = {1'b1, model_rd(idx)};
        i_dmc_host_model.send(rw, idx, data, int'($urandom % 2));
        chk_rd({rd_valid_r, rd_data_r}, exp);
        if (!rw && idx == dmc_pkg::IDX_MODE) begin
            chk_out({8'h00, sys_reset_pulse_r}, {8'h00, data[6]});
            m_mode[5:2] = data[5:2];
            if (data[1:0] != 2'b11)
                m_mode[1:0] = data[1:0];
        end
        if (!rw && idx == dmc_pkg::IDX_ZCTL)
            m_zctl = data[2:0];
    endtask

    // stored fields, derived selections and zero pins
    task automatic chk_state();
        logic [8:0] g;
        logic [8:0] e;
        g = {3'h0, one_bit_stream_mode, filter_bypass_sel,
            single_channel_sel, channel_pick, modulator_rate_sel};
        chk_out(g, {3'h0, m_mode});
        g = {6'h00, stream_zero_pattern_sel, pcm_zero_flag_en};
        chk_out(g, {6'h00, m_zctl});
        g = {3'h0, mono_right_sel_r, stream_mono_primary_r, pcm_os_rate_r,
            stream_bitclk_rate_r};
        e = {3'h0, m_mode[3] & !m_mode[5] & m_mode[2], m_mode[3] & m_mode[5],
            m_mode[5] ? 2'b00 : m_mode[1:0], m_mode[5] ? m_mode[1:0] : 2'b00};
        chk_out(g, e);
        e = {1'b0, model_rd(dmc_pkg::IDX_FLAG)};
        g = {7'h00, zero_pin_right, zero_pin_left};
        chk_out(g, e);
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************************************
    // stimulus
    // ****************************************************************
    // reset, reset values, refused indexes, random settings
    initial begin
        logic [7:0] d;
        void'($urandom(32'h4bf9));
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        chk_state();
        for (int k = 0; k < 4; k++) begin
            cmd(1'b1, 7'h14 + 7'(k), 8'($urandom));
            cmd(1'b0, 7'h16 + 7'(k % 2), 8'($urandom));
        end
        for (int k = 0; k < 8; k++)
            cmd(k[0], 7'($urandom) | 7'h18, 8'($urandom));
        cmd(1'b1, 7'h13, 8'h00);
        for (int i = 0; i < 32; i++) begin
            d = 8'($urandom);
            d = {d[7:6], i[4], d[4:2], i[1:0]};
            cmd(1'b0, dmc_pkg::IDX_MODE, d);
            d = 8'($urandom);
            d = {d[7:3], i[3:2], d[0]};
            cmd(1'b0, dmc_pkg::IDX_ZCTL, d);
            raw = 6'($urandom);
            @(negedge ref_clk);
            chk_state();
            cmd(1'b1, dmc_pkg::IDX_MODE, 8'($urandom));
            cmd(1'b1, dmc_pkg::IDX_ZCTL, 8'h00);
            cmd(1'b1, dmc_pkg::IDX_FLAG, 8'h00);
        end
        end_of_test();
    end

    // watchdog against a hung run
    initial begin
        #(4000 * 100);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
